//--- pifb_pkg.sv
package pifb_pkg;

    localparam int unsigned AXI_AW = 8;
    localparam int unsigned AXI_DW = 32;

    localparam logic [7:0] OFF_FLAGS      = 8'h00;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h08;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_CTRL       = 8'h10;
    localparam logic [7:0] OFF_RX_DATA    = 8'h14;

    localparam int unsigned BIT_GATE     = 7;
    localparam int unsigned BIT_CONV     = 6;
    localparam int unsigned BIT_RX_FULL  = 5;
    localparam int unsigned BIT_TX_EMPTY = 4;
    localparam int unsigned BIT_SYNC     = 3;
    localparam int unsigned BIT_CCP      = 2;
    localparam int unsigned BIT_PERIOD   = 1;
    localparam int unsigned BIT_OVF      = 0;
    localparam int unsigned BIT_GIE      = 0;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_WMASK = 8'hCF;
    localparam logic [7:0] IRQ_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET  = 8'h00;

    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CCP_CAPTURE = 2'b00,
        CCP_COMPARE = 2'b01,
        CCP_PWM     = 2'b10,
        CCP_OFF     = 2'b11
    } pifb_ccp_mode_t;

    typedef struct packed {
        logic           gate_active;
        logic           conv_done;
        logic           rx_full;
        logic           tx_full;
        logic           sync_done;
        logic           ccp_event;
        pifb_ccp_mode_t ccp_mode;
        logic           period_match;
        logic           overflow;
    } pifb_events_t;

    typedef struct packed {
        logic        wake;
        logic        vector_load;
        logic        pc_advance;
        logic [12:0] vector_addr;
    } pifb_wake_t;

endpackage

//--- pifb_flag_bank.sv
`timescale 1ns/1ps
// What this block does
// - Each flag sets on its event whatever the enables and global enable say.
// - Bit 7 reads 1 while timer A gate inactive; while active it holds until software writes 0; read/write.
// - Bit 6 sets on conversion done, else stays 0; software clears by writing 0.
// - Bit 5 read-only, high while receive buffer full; data read clears it.
// - Bit 4 read-only, low while transmit buffer full, high when it has room.
// - Bit 3 sets when a sync serial transfer completes; software clears it.
// - Bit 2 sets on capture or compare match; unused in pulse-width mode.
// - Bit 1 sets on timer B period match; software clears it.
// - Bit 0 sets on timer A overflow; software clears it.
// - Wake with global enable set loads the interrupt vector, not PC plus one.
// - Wake-up leaves the cause's flag set and other flags unchanged.
module pifb_flag_bank (
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    input  wire pifb_pkg::pifb_events_t i_ev,
    input  wire logic [7:0]            i_rx_data,
    output logic                       o_rx_pop,
    input  wire logic                  i_sleep_enter,
    output pifb_pkg::pifb_wake_t       o_wake,
    output logic [7:0]                 o_flags,
    output logic                       o_irq,
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [7:0]            i_awaddr,
    input  wire logic [2:0]            i_awprot,
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    output logic [1:0]                 o_bresp,
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    input  wire logic [7:0]            i_araddr,
    input  wire logic [2:0]            i_arprot,
    output logic                       o_rvalid,
    input  wire logic                  i_rready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp
);

    // Stored flags, their software-visible view and the per-cycle set vector.
    logic [7:0]  flag_r;
    logic [7:0]  flag_nxt;
    logic [7:0]  flags_rd;
    logic [7:0]  prev_rd_r;
    logic [7:0]  set_v;

    // Interrupt status, enable and global control.
    logic [7:0]  status_r;
    logic [7:0]  enable_r;
    logic [7:0]  ctrl_r;

    // Receive buffer release and sleep state.
    logic        rx_pop_r;
    logic        sleep_r;

    // Register bus holding registers and decoded strobes.
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic        wr_do;
    logic        wr_lane0;
    logic [7:0]  wr_byte;
    logic        ar_hs;
    logic [7:0]  ar_word;
    logic [7:0]  aw_word;
    logic        wake_now;
    pifb_pkg::pifb_wake_t wake_r;

    // Event decode. Sources set independently of any enable.
    // A capture/compare event outside capture and compare modes is dropped.
    // The gate flag is re-set every cycle the gate stays inactive.
    always_comb begin
        set_v                          = 8'h00;
        set_v[pifb_pkg::BIT_GATE]      = ~i_ev.gate_active;
        set_v[pifb_pkg::BIT_CONV]      = i_ev.conv_done;
        set_v[pifb_pkg::BIT_SYNC]      = i_ev.sync_done;
        set_v[pifb_pkg::BIT_CCP]       = i_ev.ccp_event &
            ((i_ev.ccp_mode == pifb_pkg::CCP_CAPTURE) |
             (i_ev.ccp_mode == pifb_pkg::CCP_COMPARE));
        set_v[pifb_pkg::BIT_PERIOD]    = i_ev.period_match;
        set_v[pifb_pkg::BIT_OVF]       = i_ev.overflow;
    end

    // Composite read view: stored flags plus the two live buffer levels.
    always_comb begin
        flags_rd                           = flag_r;
        flags_rd[pifb_pkg::BIT_RX_FULL]    = i_ev.rx_full & ~rx_pop_r;
        flags_rd[pifb_pkg::BIT_TX_EMPTY]   = ~i_ev.tx_full;
    end

    assign aw_word  = {awaddr_r[7:2], 2'b00};
    assign ar_word  = {i_araddr[7:2], 2'b00};
    assign wr_do    = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_lane0 = wr_do & wstrb_r[0];
    assign wr_byte  = wdata_r[7:0];
    assign ar_hs    = i_arvalid & ~rvalid_r;

    // A write replaces the writable bits; an event in the same cycle wins.
    // The mask keeps the two live serial bits out of storage.
    // Only byte lane 0 carries register data.
    always_comb begin
        flag_nxt = flag_r;
        if (wr_lane0 && aw_word == pifb_pkg::OFF_FLAGS) begin
            flag_nxt = wr_byte;
        end
        flag_nxt = (flag_nxt | set_v) & pifb_pkg::FLAGS_WMASK;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            flag_r <= pifb_pkg::FLAGS_RESET;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Sticky status catches each rising edge of a visible flag.
    // The edge history follows the live view in reset, so a buffer level
    // that is already high at release does not look like a new event.
    // A clear and a new edge in one cycle leave the bit set.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            prev_rd_r <= flags_rd;
            status_r  <= pifb_pkg::IRQ_RESET;
        end else begin
            prev_rd_r <= flags_rd;
            if (wr_lane0 && aw_word == pifb_pkg::OFF_IRQ_CLEAR) begin
                status_r <= (status_r & ~wr_byte) | (flags_rd & ~prev_rd_r);
            end else begin
                status_r <= status_r | (flags_rd & ~prev_rd_r);
            end
        end
    end

    // Enable doubles as the wake mask; control keeps only the global enable.
    // Status and receive data words are not writable.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            enable_r <= pifb_pkg::IRQ_RESET;
            ctrl_r   <= pifb_pkg::CTRL_RESET;
        end else begin
            if (wr_lane0 && aw_word == pifb_pkg::OFF_IRQ_ENABLE) begin
                enable_r <= wr_byte;
            end
            if (wr_lane0 && aw_word == pifb_pkg::OFF_CTRL) begin
                ctrl_r <= {7'h00, wr_byte[pifb_pkg::BIT_GIE]};
            end
        end
    end

    // The level interrupt is high while any enabled status bit is set.
    // It is built only from registers, so it carries no event glitch.
    assign o_irq   = |(status_r & enable_r);
    assign o_flags = flags_rd;

    // Reading the receive data word releases the receive buffer.
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            rx_pop_r <= 1'b0;
        end else begin
            rx_pop_r <= ar_hs & (ar_word == pifb_pkg::OFF_RX_DATA);
        end
    end

    assign o_rx_pop = rx_pop_r;

    // Sleep and wake. An enabled pending flag ends sleep.
    // Wake wins over a same-cycle sleep request so no wake is lost.
    // The flags are not touched here: the cause stays set, the rest keep
    // their values.
    assign wake_now = sleep_r & |(flags_rd & enable_r);

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sleep_r <= 1'b0;
            wake_r  <= '0;
        end else begin
            if (wake_now) begin
                sleep_r <= 1'b0;
            end else if (i_sleep_enter) begin
                sleep_r <= 1'b1;
            end
            wake_r.wake        <= wake_now;
            wake_r.vector_load <= wake_now & ctrl_r[pifb_pkg::BIT_GIE];
            wake_r.pc_advance  <= wake_now & ~ctrl_r[pifb_pkg::BIT_GIE];
            wake_r.vector_addr <= pifb_pkg::IRQ_VECTOR;
        end
    end

    assign o_wake = wake_r;

    // AXI4-Lite write path: address and data taken in either order.
    // Each channel is held until both are present, then the write lands
    // in the same edge that raises the response.
    // Both readies stay low while a response waits.
    assign o_awready = ~aw_held_r & ~bvalid_r;
    assign o_wready  = ~w_held_r & ~bvalid_r;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= 8'h00;
        end else if (wr_do) begin
            aw_held_r <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= i_awaddr;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            w_held_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (wr_do) begin
            w_held_r <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= i_wdata;
            wstrb_r  <= i_wstrb;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= pifb_pkg::RESP_OKAY;
        end else if (wr_do) begin
            // Unmapped words answer with an error and change nothing.
            bvalid_r <= 1'b1;
            unique case (aw_word)
                pifb_pkg::OFF_FLAGS,
                pifb_pkg::OFF_IRQ_STATUS,
                pifb_pkg::OFF_IRQ_CLEAR,
                pifb_pkg::OFF_IRQ_ENABLE,
                pifb_pkg::OFF_CTRL,
                pifb_pkg::OFF_RX_DATA: bresp_r <= pifb_pkg::RESP_OKAY;
                default:               bresp_r <= pifb_pkg::RESP_SLVERR;
            endcase
        end else if (i_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_r;
    assign o_bresp  = bresp_r;

    // AXI4-Lite read path: answer one cycle after the address is taken.
    // Only one read is in flight; the address is refused while data waits.
    // Data are captured at the handshake, so a later event cannot tear them.
    assign o_arready = ~rvalid_r;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= pifb_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            // Registers sit in the low byte; upper bits read as zero.
            rvalid_r <= 1'b1;
            rresp_r  <= pifb_pkg::RESP_OKAY;
            unique case (ar_word)
                pifb_pkg::OFF_FLAGS:      rdata_r <= {24'h000000, flags_rd};
                pifb_pkg::OFF_IRQ_STATUS: rdata_r <= {24'h000000, status_r};
                pifb_pkg::OFF_IRQ_CLEAR:  rdata_r <= 32'h0000_0000;
                pifb_pkg::OFF_IRQ_ENABLE: rdata_r <= {24'h000000, enable_r};
                pifb_pkg::OFF_CTRL:       rdata_r <= {24'h000000, ctrl_r};
                pifb_pkg::OFF_RX_DATA:    rdata_r <= {24'h000000, i_rx_data};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= pifb_pkg::RESP_SLVERR;
                end
            endcase
        end else if (i_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_r;
    assign o_rdata  = rdata_r;
    assign o_rresp  = rresp_r;

endmodule // pifb_flag_bank

//--- pifb_properties.sv
`timescale 1ns/1ps
module pifb_properties (
    input logic                   i_mclk,
    input logic                   i_nrst,
    input pifb_pkg::pifb_events_t i_ev,
    input logic                   i_arvalid,
    input logic                   o_arready,
    input logic [7:0]             i_araddr,
    input logic                   o_rx_pop,
    input pifb_pkg::pifb_wake_t   o_wake,
    input logic [7:0]             o_flags
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    sequence rx_read;
        i_arvalid && o_arready && i_araddr == pifb_pkg::OFF_RX_DATA;
    endsequence
    sequence pop_once;
        o_rx_pop ##1 !o_rx_pop;
    endsequence
    AST_OVF: assert property (i_ev.overflow |=> o_flags[0])
        else $error("overflow flag missed");
    AST_PER: assert property (i_ev.period_match |=> o_flags[1])
        else $error("period flag missed");
    AST_SYNC: assert property (i_ev.sync_done |=> o_flags[3])
        else $error("sync flag missed");
    AST_CONV: assert property (i_ev.conv_done |=> o_flags[6])
        else $error("conversion flag missed");
    AST_CCP: assert property (i_ev.ccp_event && !i_ev.ccp_mode[1] |=> o_flags[2])
        else $error("capture flag missed");
    AST_GATE: assert property (!i_ev.gate_active |=> o_flags[7])
        else $error("gate flag low");
    AST_TX: assert property (o_flags[4] != i_ev.tx_full)
        else $error("tx flag wrong");
    AST_RX: assert property (o_flags[5] == (i_ev.rx_full && !o_rx_pop))
        else $error("rx flag wrong");
    AST_POP: assert property (rx_read |=> pop_once)
        else $error("no pop pulse");
    AST_VEC: assert property (o_wake.vector_load |->
        o_wake.wake && !o_wake.pc_advance && o_wake.vector_addr == pifb_pkg::IRQ_VECTOR)
        else $error("bad vector load");
endmodule // pifb_properties

bind pifb_flag_bank pifb_properties u_props (.*);

//--- pifb_periph_model.sv
`timescale 1ns/1ps
module pifb_periph_model (
    input  wire logic              i_mclk,
    input  wire logic              i_rx_pop,
    output pifb_pkg::pifb_events_t o_ev,
    output logic [7:0]             o_rx_data
);
    initial begin
        o_ev = '0;
        o_rx_data = 8'h00;
    end
    task automatic pulse(input logic [9:0] m);
        @(posedge i_mclk);
        o_ev <= o_ev | m;
        @(posedge i_mclk);
        o_ev <= o_ev & ~m;
    endtask
    task automatic level(input int b, input logic v);
        @(posedge i_mclk);
        o_ev[b] <= v;
    endtask
    task automatic deliver(input logic [7:0] d);
        @(posedge i_mclk);
        o_rx_data <= d;
        o_ev.rx_full <= 1'b1;
    endtask
    // A popped buffer empties and its stale byte is inverted so it cannot pass twice.
    always @(posedge i_mclk) begin
        if (i_rx_pop) begin
            o_ev.rx_full <= 1'b0;
            o_rx_data <= ~o_rx_data;
        end
    end
endmodule // pifb_periph_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        i_mclk, i_nrst, i_sleep_enter, o_rx_pop, o_irq;
    logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
    logic        i_arvalid, o_arready, o_rvalid, i_rready;
    logic [7:0]  i_awaddr, i_araddr, i_rx_data, o_flags;
    logic [2:0]  i_awprot, i_arprot;
    logic [3:0]  i_wstrb;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [1:0]  o_bresp, o_rresp, rs;
    pifb_pkg::pifb_events_t i_ev;
    pifb_pkg::pifb_wake_t   o_wake;
    int          mismatches = 0, tests_run = 0, cyc = 0;
    logic [9:0]  evm [8] = '{10'h001, 10'h002, 10'h020, 10'h100,
                             10'h010, 10'h014, 10'h018, 10'h01C};
    logic [7:0]  evx [8] = '{8'h91, 8'h92, 8'h98, 8'hD0, 8'h94, 8'h94, 8'h90, 8'h90};

    pifb_flag_bank DUT (.*);
    pifb_periph_model PM (.i_mclk(i_mclk), .i_rx_pop(o_rx_pop), .o_ev(i_ev),
                          .o_rx_data(i_rx_data));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, ta, tw;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(negedge i_mclk);
            ta = pa && o_awready;
            tw = pw && o_wready;
            @(posedge i_mclk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge i_mclk); while (!o_bvalid);
        chk("bresp", 32'(o_bresp), 32'(er));
        @(posedge i_mclk);
        i_bready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(negedge i_mclk); while (!o_arready);
        @(posedge i_mclk);
        i_arvalid <= 1'b0;
        do @(negedge i_mclk); while (!o_rvalid);
        rv = o_rdata;
        rs = o_rresp;
        @(posedge i_mclk);
        i_rready <= 1'b0;
        chk(nm, rv, e);
        chk("rresp", 32'(rs), 32'(a > 8'h17 ? pifb_pkg::RESP_SLVERR : pifb_pkg::RESP_OKAY));
    endtask
    task automatic irq(input logic e);
        @(negedge i_mclk);
        chk("irq", 32'(o_irq), 32'(e));
    endtask
    task automatic slp(input logic global_irq_enable);
        wr(pifb_pkg::OFF_CTRL, 32'(global_irq_enable), pifb_pkg::RESP_OKAY);
        @(posedge i_mclk);
        i_sleep_enter <= 1'b1;
        @(posedge i_mclk);
        i_sleep_enter <= 1'b0;
        PM.pulse(10'h001);
        do @(negedge i_mclk); while (!o_wake.wake);
        chk("vector_load", 32'(o_wake.vector_load), 32'(global_irq_enable));
        chk("pc_advance", 32'(o_wake.pc_advance), 32'(!global_irq_enable));
        chk("vector_addr", 32'(o_wake.vector_addr), 32'h0004);
        rc(pifb_pkg::OFF_FLAGS, 32'h91, "wake flags");
        wr(pifb_pkg::OFF_FLAGS, 32'h80, pifb_pkg::RESP_OKAY);
    endtask

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        {i_nrst, i_sleep_enter, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h00;
        {i_awaddr, i_araddr, i_wdata, i_awprot, i_arprot} = 54'h0;
        i_wstrb = 4'hF;
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rc(pifb_pkg::OFF_FLAGS, 32'h90, "flags reset");
        rc(pifb_pkg::OFF_IRQ_ENABLE, 32'h0, "enable reset");
        rc(pifb_pkg::OFF_IRQ_STATUS, 32'h80, "status reset");
        rc(8'h18, 32'h0, "unmapped");
        wr(8'h18, 32'hFF, pifb_pkg::RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            PM.pulse(evm[i]);
            rc(pifb_pkg::OFF_FLAGS, 32'(evx[i]), "event flag");
            wr(pifb_pkg::OFF_FLAGS, 32'h80, pifb_pkg::RESP_OKAY);
        end
        rc(pifb_pkg::OFF_FLAGS, 32'h90, "flags cleared");
        $display("test events done");
        PM.level(9, 1'b1);
        wr(pifb_pkg::OFF_FLAGS, 32'h00, pifb_pkg::RESP_OKAY);
        rc(pifb_pkg::OFF_FLAGS, 32'h10, "gate active");
        PM.level(9, 1'b0);
        rc(pifb_pkg::OFF_FLAGS, 32'h90, "gate inactive");
        PM.level(6, 1'b1);
        PM.deliver(8'hA5);
        wr(pifb_pkg::OFF_FLAGS, 32'h10, pifb_pkg::RESP_OKAY);
        rc(pifb_pkg::OFF_FLAGS, 32'hA0, "serial bits");
        rc(pifb_pkg::OFF_RX_DATA, 32'hA5, "rx data");
        rc(pifb_pkg::OFF_FLAGS, 32'h80, "rx popped");
        PM.level(6, 1'b0);
        rc(pifb_pkg::OFF_FLAGS, 32'h90, "tx empty");
        $display("test gate and serial done");
        wr(pifb_pkg::OFF_IRQ_CLEAR, 32'hFF, pifb_pkg::RESP_OKAY);
        rc(pifb_pkg::OFF_IRQ_STATUS, 32'h0, "status cleared");
        wr(pifb_pkg::OFF_IRQ_ENABLE, 32'h01, pifb_pkg::RESP_OKAY);
        irq(1'b0);
        PM.pulse(10'h001);
        rc(pifb_pkg::OFF_IRQ_STATUS, 32'h01, "status set");
        irq(1'b1);
        wr(pifb_pkg::OFF_IRQ_ENABLE, 32'h00, pifb_pkg::RESP_OKAY);
        irq(1'b0);
        wr(pifb_pkg::OFF_IRQ_ENABLE, 32'h01, pifb_pkg::RESP_OKAY);
        irq(1'b1);
        wr(pifb_pkg::OFF_IRQ_CLEAR, 32'h01, pifb_pkg::RESP_OKAY);
        irq(1'b0);
        wr(pifb_pkg::OFF_FLAGS, 32'h80, pifb_pkg::RESP_OKAY);
        $display("test interrupt done");
        slp(1'b1);
        slp(1'b0);
        $display("test wake done");
        summarize();
    end
endmodule // tb_top
